// *** logic/adc_conv_params.svh ***
// Purpose: Offsets, fields, reset values and timing for the converter control
// Assumes: Byte address of a register is four times its index
// Notes: Definitions only
`ifndef ADC_CONV_PARAMS_SVH
`define ADC_CONV_PARAMS_SVH
// Register indices
`define IDX_PORT_A_PINS 8'h05
`define IDX_INTERRUPT_CONTROL 8'h0b
`define IDX_PERIPH_IRQ_FLAGS 8'h0c
`define IDX_CCP_CONTROL 8'h17
`define IDX_CONVERSION_RESULT 8'h1e
`define IDX_CONVERTER_CONTROL 8'h1f
`define IDX_PORT_A_DIRECTION 8'h85
`define IDX_PERIPH_IRQ_ENABLES 8'h8c
`define IDX_CONVERTER_PIN_CONFIG 8'h9f
// Reset values
`define RST_ZERO 8'h00
`define RST_PORT_A_DIRECTION 8'h3f
`define RST_READY 1'h1
// Fields of converter_control
`define CLKSEL_MSB 7
`define CLKSEL_LSB 6
`define CHAN_MSB 5
`define CHAN_LSB 3
`define GO_BIT 2
`define ON_BIT 0
`define CTL_MASK 8'hfd
`define CLKSEL_RC 2'h3
// Fields of other registers
`define DONE_BIT 6
`define CCP_FLAG_BIT 2
`define FLAG_MASK 8'h4f
`define PIN_CFG_MASK 8'h07
`define CCP_CTL_MASK 8'h3f
`define PORT_A_MASK 8'h3f
`define CCP_MODE_MSB 3
`define CCP_MODE_LSB 0
`define CCP_MODE_SPECIAL 4'hb
// Timing, in ref_clk cycles
`define OSC_PER_INSTR 4
`define INSTR_CLKS 4'h4
`define CONV_CLKS 4'ha
`define CNT_ONE 4'h1
`define CNT_ZERO 4'h0
`endif

// *** logic/adc_conv_pkg.sv ***
// Purpose: Types shared by the converter control
// Assumes: AHB-Lite single word transfers
// Notes: Types only; numbers live in the params header
package adc_conv_pkg;
   typedef struct packed {
      logic hsel;
      logic [11:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
      logic [31:0] hwdata;
   } ahbReq_type;
   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } ahbRsp_type;
   typedef struct packed {
      logic powered;
      logic sampling;
      logic [2:0] channel;
      logic [2:0] pinConfig;
   } analogCtl_type;
   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} convState_type;
endpackage : adc_conv_pkg

// *** logic/adc_conversion_control.sv ***
// Purpose: Converter control, trigger handling and AHB-Lite register file
// Assumes: ref_clk 125 MHz; sleep and trigger inputs synchronous
// Notes: Result register is left uninitialised on reset
//
// Overview of operation
// - Converter keeps running in sleep only with RC conversion clock (select 11).
// - With RC clock, actual conversion start waits one instruction cycle after go.
// - Completion clears go and loads the result register.
// - Completion in sleep with interrupt enabled wakes the device.
// - Completion in sleep with interrupt disabled leaves converter-on set, no wake.
// - Sleep with non-RC clock aborts conversion, powers down, converter-on stays.
// - Reset restores register values, disables converter, aborts conversion.
// - Reset makes all shared converter pins analog inputs.
// - Result register is undefined after power-on; no initialisation needed.
// - Special event in mode 1011 with converter on sets go.
// - Every special event in mode 1011 clears the capture timer.
// - Converter off ignores special event; timer still cleared.
//
// Register access over AHB-Lite was decided locally.
`include "adc_conv_params.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Register bus
   input wire adc_conv_pkg::ahbReq_type ahbReq,
   output adc_conv_pkg::ahbRsp_type ahbRsp,
   // Core and trigger side
   input wire logic sleepMode,
   input wire logic specialEvent,
   input wire logic [7:0] sampleData,
   output logic timerClear,
   output logic wakeUp,
   output logic irq,
   // Analog front end
   output adc_conv_pkg::analogCtl_type analogCtl
);
   function automatic logic [7:0] wr(input logic [7:0] old, input logic [7:0] val,
                                     input logic [7:0] mask);
      wr = (old & ~mask) | (val & mask);
   endfunction : wr

   // Bus state
   logic wrPend_q, wrPend_d;
   logic [7:0] wrIdx_q, wrIdx_d;
   logic [31:0] rdata_q, rdata_d;
   logic ready_q;
   logic addrOk;
   logic [7:0] aIdx;
   logic wrEn;
   logic [7:0] wData;

   // Register and engine state
   logic [7:0] port_a_pins_q, port_a_pins_d, intCtl_q, intCtl_d, flags_q, flags_d;
   logic [7:0] ccpCtl_q, ccpCtl_d, result_q, result_d, ctl_q, ctl_d;
   logic [7:0] port_a_direction_q, port_a_direction_d, enables_q, enables_d, pinCfg_q, pinCfg_d;
   adc_conv_pkg::convState_type state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic timerClear_q, timerClear_d, wake_q, wake_d, irq_q, irq_d;
   logic powered_q, powered_d;
   logic isRc, trig, done, abort;

   assign aIdx = ahbReq.haddr[9:2];
   assign addrOk = ahbReq.hsel & ahbReq.htrans[1] & ahbReq.hready;
   assign wrEn = wrPend_q;
   assign wData = ahbReq.hwdata[7:0];

   always_comb begin
      wrPend_d = addrOk & ahbReq.hwrite;
      wrIdx_d = aIdx;
      rdata_d = rdata_q;
      if (addrOk & ~ahbReq.hwrite) begin
         rdata_d = 32'h0;
         unique case (aIdx)
            `IDX_PORT_A_PINS: rdata_d[7:0] = port_a_pins_q;
            `IDX_INTERRUPT_CONTROL: rdata_d[7:0] = intCtl_q;
            `IDX_PERIPH_IRQ_FLAGS: rdata_d[7:0] = flags_q;
            `IDX_CCP_CONTROL: rdata_d[7:0] = ccpCtl_q;
            `IDX_CONVERSION_RESULT: rdata_d[7:0] = result_q;
            `IDX_CONVERTER_CONTROL: rdata_d[7:0] = ctl_q;
            `IDX_PORT_A_DIRECTION: rdata_d[7:0] = port_a_direction_q;
            `IDX_PERIPH_IRQ_ENABLES: rdata_d[7:0] = enables_q;
            `IDX_CONVERTER_PIN_CONFIG: rdata_d[7:0] = pinCfg_q;
            default: rdata_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         wrPend_q <= 1'b0;
         wrIdx_q <= `RST_ZERO;
         rdata_q <= 32'h0;
         ready_q <= `RST_READY;
      end else begin
         wrPend_q <= wrPend_d;
         wrIdx_q <= wrIdx_d;
         rdata_q <= rdata_d;
         ready_q <= `RST_READY;
      end
   end

   assign ahbRsp.hreadyout = ready_q;
   assign ahbRsp.hresp = 1'b0;
   assign ahbRsp.hrdata = rdata_q;

   assign isRc = ctl_q[`CLKSEL_MSB:`CLKSEL_LSB] == `CLKSEL_RC;
   // Non-RC clock cannot run while the core clock is stopped
   assign abort = sleepMode & ~isRc;
   assign trig = specialEvent
                 & (ccpCtl_q[`CCP_MODE_MSB:`CCP_MODE_LSB] == `CCP_MODE_SPECIAL);
   assign done = (state_q == adc_conv_pkg::ST_CONV) & (cnt_q == `CNT_ONE) & ~abort;

   always_comb begin
      port_a_pins_d = port_a_pins_q;
      intCtl_d = intCtl_q;
      flags_d = flags_q;
      ccpCtl_d = ccpCtl_q;
      result_d = result_q;
      ctl_d = ctl_q;
      port_a_direction_d = port_a_direction_q;
      enables_d = enables_q;
      pinCfg_d = pinCfg_q;
      state_d = state_q;
      cnt_d = cnt_q;
      if (wrEn) begin
         unique case (wrIdx_q)
            `IDX_PORT_A_PINS: port_a_pins_d = wData & `PORT_A_MASK;
            `IDX_INTERRUPT_CONTROL: intCtl_d = wData;
            `IDX_PERIPH_IRQ_FLAGS: flags_d = flags_q & ~wData;
            `IDX_CCP_CONTROL: ccpCtl_d = wData & `CCP_CTL_MASK;
            `IDX_CONVERTER_CONTROL: ctl_d = wr(ctl_q, wData, `CTL_MASK);
            `IDX_PORT_A_DIRECTION: port_a_direction_d = wData & `PORT_A_MASK;
            `IDX_PERIPH_IRQ_ENABLES: enables_d = wData & `FLAG_MASK;
            `IDX_CONVERTER_PIN_CONFIG: pinCfg_d = wData & `PIN_CFG_MASK;
            default: ;
         endcase
      end
      unique case (state_q)
         adc_conv_pkg::ST_IDLE: begin
            if (ctl_q[`GO_BIT] & ctl_q[`ON_BIT] & ~abort) begin
               // RC start lags so the sleep instruction can settle noise
               state_d = isRc ? adc_conv_pkg::ST_DELAY : adc_conv_pkg::ST_CONV;
               cnt_d = isRc ? `INSTR_CLKS : `CONV_CLKS;
            end
         end
         adc_conv_pkg::ST_DELAY: begin
            cnt_d = cnt_q - `CNT_ONE;
            if (cnt_q == `CNT_ONE) begin
               state_d = adc_conv_pkg::ST_CONV;
               cnt_d = `CONV_CLKS;
            end
         end
         adc_conv_pkg::ST_CONV: begin
            cnt_d = cnt_q - `CNT_ONE;
            if (done) begin
               state_d = adc_conv_pkg::ST_IDLE;
               ctl_d[`GO_BIT] = 1'b0;
               result_d = sampleData;
            end
         end
      endcase
      // Abort leaves converter_on as software left it
      // A pending go is dropped too, so waking cannot start a stale conversion
      if (abort | (~ctl_q[`ON_BIT] & (state_q != adc_conv_pkg::ST_IDLE))) begin
         state_d = adc_conv_pkg::ST_IDLE;
         ctl_d[`GO_BIT] = 1'b0;
      end
      if (trig & ctl_q[`ON_BIT]) begin
         ctl_d[`GO_BIT] = 1'b1;
      end
      // Hardware sets win over software clears
      if (done) begin
         flags_d[`DONE_BIT] = 1'b1;
      end
      if (trig) begin
         flags_d[`CCP_FLAG_BIT] = 1'b1;
      end
      timerClear_d = trig;
      wake_d = done & sleepMode & enables_q[`DONE_BIT];
      irq_d = |(flags_d & enables_d);
      powered_d = ctl_d[`ON_BIT] & ~(sleepMode & ~isRc);
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         // Full reset of control state also aborts any conversion
         port_a_pins_q <= `RST_ZERO;
         intCtl_q <= `RST_ZERO;
         flags_q <= `RST_ZERO;
         ccpCtl_q <= `RST_ZERO;
         ctl_q <= `RST_ZERO;
         port_a_direction_q <= `RST_PORT_A_DIRECTION;
         enables_q <= `RST_ZERO;
         pinCfg_q <= `RST_ZERO;
         state_q <= adc_conv_pkg::ST_IDLE;
         cnt_q <= `CNT_ZERO;
         timerClear_q <= 1'b0;
         wake_q <= 1'b0;
         irq_q <= 1'b0;
         powered_q <= 1'b0;
      end else begin
         port_a_pins_q <= port_a_pins_d;
         intCtl_q <= intCtl_d;
         flags_q <= flags_d;
         ccpCtl_q <= ccpCtl_d;
         ctl_q <= ctl_d;
         port_a_direction_q <= port_a_direction_d;
         enables_q <= enables_d;
         pinCfg_q <= pinCfg_d;
         state_q <= state_d;
         cnt_q <= cnt_d;
         timerClear_q <= timerClear_d;
         wake_q <= wake_d;
         irq_q <= irq_d;
         powered_q <= powered_d;
      end
   end

   // Result keeps no reset; its content is undefined until a conversion
   always_ff @(posedge ref_clk) begin
      result_q <= result_d;
   end

   assign timerClear = timerClear_q;
   assign wakeUp = wake_q;
   assign irq = irq_q;
   assign analogCtl.powered = powered_q;
   assign analogCtl.sampling = state_q == adc_conv_pkg::ST_CONV;
   assign analogCtl.channel = ctl_q[`CHAN_MSB:`CHAN_LSB];
   assign analogCtl.pinConfig = pinCfg_q[2:0];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence s_rcStart;
      state_q == adc_conv_pkg::ST_IDLE && ctl_q[`GO_BIT] && ctl_q[`ON_BIT] && isRc
      && !wrEn;
   endsequence
   sequence s_delayRun;
      state_q == adc_conv_pkg::ST_DELAY [*4];
   endsequence

   property p_rcDelay;
      s_rcStart |=> s_delayRun ##1 state_q == adc_conv_pkg::ST_CONV;
   endproperty
   a_rcDelay: assert property (p_rcDelay) else $error("RC start not delayed");

   property p_doneClearsGo;
      done |=> !ctl_q[`GO_BIT] || $past(trig) ;
   endproperty
   a_doneClearsGo: assert property (p_doneClearsGo) else $error("go not cleared");

   property p_resultLoad;
      done |=> result_q == $past(sampleData);
   endproperty
   a_resultLoad: assert property (p_resultLoad) else $error("result not loaded");

   property p_wake;
      done && sleepMode && enables_q[`DONE_BIT] |=> wakeUp;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on done");

   property p_noWake;
      wakeUp |-> $past(enables_q[`DONE_BIT]) && $past(sleepMode);
   endproperty
   a_noWake: assert property (p_noWake) else $error("wake without enable");

   property p_sleepAbort;
      sleepMode && !isRc && state_q != adc_conv_pkg::ST_IDLE
      |=> state_q == adc_conv_pkg::ST_IDLE && !analogCtl.powered;
   endproperty
   a_sleepAbort: assert property (p_sleepAbort) else $error("no abort in sleep");

   property p_onKept;
      sleepMode && ctl_q[`ON_BIT] && !wrEn |=> ctl_q[`ON_BIT];
   endproperty
   a_onKept: assert property (p_onKept) else $error("converter_on dropped");

   property p_trigGo;
      trig && ctl_q[`ON_BIT] |=> ctl_q[`GO_BIT] && timerClear;
   endproperty
   a_trigGo: assert property (p_trigGo) else $error("trigger lost");

   property p_timerClear;
      timerClear |-> $past(specialEvent);
   endproperty
   a_timerClear: assert property (p_timerClear) else $error("spurious clear");

   property p_trigIgnored;
      trig && !ctl_q[`ON_BIT] && !ctl_q[`GO_BIT] && !wrEn |=> !ctl_q[`GO_BIT] && timerClear;
   endproperty
   a_trigIgnored: assert property (p_trigIgnored) else $error("off trigger used");

   property p_doneFlag;
      done |=> flags_q[`DONE_BIT];
   endproperty
   a_doneFlag: assert property (p_doneFlag) else $error("done flag missing");

   property p_resetState;
      disable iff (1'b0) !resetn |=> ctl_q == `RST_ZERO && pinCfg_q == `RST_ZERO
                                     && state_q == adc_conv_pkg::ST_IDLE;
   endproperty
   a_resetState: assert property (p_resetState) else $error("reset incomplete");

   property p_abortGo;
      abort |=> !ctl_q[`GO_BIT] || $past(trig);
   endproperty
   a_abortGo: assert property (p_abortGo) else $error("go kept on abort");

   property p_rcPowered;
      sleepMode && isRc && ctl_q[`ON_BIT] && !wrEn |=> analogCtl.powered;
   endproperty
   a_rcPowered: assert property (p_rcPowered) else $error("RC converter powered down");

   property p_rcRun;
      sleepMode && isRc && state_q != adc_conv_pkg::ST_IDLE && ctl_q[`ON_BIT] && !wrEn
      |=> state_q != adc_conv_pkg::ST_IDLE || $past(done);
   endproperty
   a_rcRun: assert property (p_rcRun) else $error("RC conversion stopped in sleep");

   property p_directStart;
      state_q == adc_conv_pkg::ST_IDLE && ctl_q[`GO_BIT] && ctl_q[`ON_BIT] && !isRc && !abort
      |=> state_q == adc_conv_pkg::ST_CONV && cnt_q == `CONV_CLKS;
   endproperty
   a_directStart: assert property (p_directStart) else $error("non-RC start delayed");

   property p_doneIdle;
      done |=> state_q == adc_conv_pkg::ST_IDLE;
   endproperty
   a_doneIdle: assert property (p_doneIdle) else $error("still converting");

   property p_wakePulse;
      wakeUp |=> !wakeUp;
   endproperty
   a_wakePulse: assert property (p_wakePulse) else $error("wake longer than a cycle");

   property p_trigFlag;
      trig |=> flags_q[`CCP_FLAG_BIT];
   endproperty
   a_trigFlag: assert property (p_trigFlag) else $error("event flag missing");

   property p_irqSet;
      done && enables_q[`DONE_BIT] && !wrEn |=> irq;
   endproperty
   a_irqSet: assert property (p_irqSet) else $error("no interrupt on done");
endmodule : adc_conversion_control
`default_nettype wire

// *** verif/core_trigger_model.sv ***
// Purpose: Core and capture/compare side facing the converter control
// Assumes: Bench calls the tasks just after a rising edge
// Notes: Capture timer runs freely and is cleared by the block
`timescale 1ns/1ps
`default_nettype none
module core_trigger_model (
   // Clock
   input wire logic ref_clk,
   // From the block
   input wire logic timerClear,
   // To the block
   output var logic sleepMode,
   output var logic specialEvent,
   output var logic [7:0] sampleData
);
   logic [15:0] captureTimer;
   initial begin
      sleepMode = 1'b0;
      specialEvent = 1'b0;
      sampleData = 8'h00;
      captureTimer = 16'h0000;
   end
   always @(posedge ref_clk) begin
      captureTimer <= timerClear ? 16'h0000 : captureTimer + 16'h0001;
   end
   // Caller sets channel and waits acquisition before firing
   task automatic fire();
      specialEvent <= 1'b1;
      @(posedge ref_clk);
      specialEvent <= 1'b0;
   endtask : fire
   task automatic setSample(input logic [7:0] d);
      sampleData <= d;
   endtask : setSample
   // Sleep comes right after the go write, or three cycles later in mid-conversion
   task automatic doze(input logic on);
      sleepMode <= on;
   endtask : doze
endmodule : core_trigger_model
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the converter control
// Assumes: Zero wait-state slave; byte address is four times the index
// Notes: Done is found by polling the flag register or the sampling output, not by cycle count
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   adc_conv_pkg::ahbReq_type req = '0;
   adc_conv_pkg::ahbReq_type busReq;
   adc_conv_pkg::ahbRsp_type rsp;
   adc_conv_pkg::analogCtl_type analogCtl;
   logic sleepMode, specialEvent, timerClear, wakeUp, irq;
   logic [7:0] sampleData;
   logic [7:0] rd;
   int bad_count = 0;
   int n_checks = 0;
   int wakes = 0;
   int clears = 0;
   always #4 ref_clk = ~ref_clk;
   // Bus hready is the slave's own hreadyout
   assign busReq = {req.hsel, req.haddr, req.htrans, req.hwrite, req.hsize, rsp.hreadyout,
      req.hwdata};
   adc_conversion_control uut (.ref_clk(ref_clk), .resetn(resetn), .ahbReq(busReq),
      .ahbRsp(rsp), .sleepMode(sleepMode), .specialEvent(specialEvent),
      .sampleData(sampleData), .timerClear(timerClear), .wakeUp(wakeUp), .irq(irq),
      .analogCtl(analogCtl));
   core_trigger_model partner (.ref_clk(ref_clk), .timerClear(timerClear),
      .sleepMode(sleepMode), .specialEvent(specialEvent), .sampleData(sampleData));
   always @(posedge ref_clk) begin
      if (wakeUp === 1'b1) wakes++;
      if (timerClear === 1'b1) clears++;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t signal %b expected %b", $time, got, exp);
      end
   endtask : chk1
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   task automatic waitReady();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (rsp.hreadyout !== 1'b1 && n < 50);
      if (rsp.hreadyout !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %0t bus never ready", $time);
      end
   endtask : waitReady
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
      req.hsel <= 1'b1;
      req.haddr <= a;
      req.htrans <= 2'h2;
      req.hwrite <= wr;
      req.hsize <= 3'h2;
      waitReady();
      req.hsel <= 1'b0;
      req.htrans <= 2'h0;
      req.hwdata <= {24'h000000, d};
      waitReady();
      rd = rsp.hrdata[7:0];
   endtask : xfer
   // Idle cycle after a write so a following read sees the new value
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
      tick(1);
   endtask : wr
   task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
      xfer(1'b0, a, 8'h00);
      chk8(rd, exp);
      chk1(rsp.hresp, 1'b0);
   endtask : rdchk
   task automatic waitDone();
      int n;
      n = 0;
      do begin
         xfer(1'b0, 12'h030, 8'h00);
         n++;
      end while (rd[6] !== 1'b1 && n < 40);
      chk1(rd[6], 1'b1);
   endtask : waitDone
   task automatic test_reset();
      logic [11:0] addrs [7];
      logic [7:0] vals [7];
      addrs = '{12'h07c, 12'h030, 12'h230, 12'h27c, 12'h05c, 12'h214, 12'h3f0};
      vals = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h00};
      chk1(analogCtl.powered, 1'b0);
      chk8({5'h00, analogCtl.pinConfig}, 8'h00);
      for (int i = 0; i < 7; i++) begin
         rdchk(addrs[i], vals[i]);
      end
   endtask : test_reset
   task automatic test_soft();
      partner.setSample(8'h5a);
      wr(12'h230, 8'h40);
      wr(12'h07c, 8'h29);
      chk1(analogCtl.powered, 1'b1);
      chk8({5'h00, analogCtl.channel}, 8'h05);
      wr(12'h07c, 8'h2d);
      // Conversion state shows one edge after go lands
      tick(1);
      chk1(analogCtl.sampling, 1'b1);
      rdchk(12'h07c, 8'h2d);
      waitDone();
      rdchk(12'h07c, 8'h29);
      rdchk(12'h078, 8'h5a);
      chk1(irq, 1'b1);
      wr(12'h230, 8'h00);
      chk1(irq, 1'b0);
      wr(12'h030, 8'h40);
      rdchk(12'h030, 8'h00);
   endtask : test_soft
   task automatic test_sleep(input logic en);
      int w0;
      int n;
      w0 = wakes;
      wr(12'h230, {1'b0, en, 6'h00});
      partner.setSample(8'hc3);
      xfer(1'b1, 12'h07c, 8'hc5);
      partner.doze(1'b1);
      tick(3);
      chk1(analogCtl.sampling, 1'b0);
      n = 0;
      while (analogCtl.sampling !== 1'b1 && n < 4) begin
         tick(1);
         n++;
      end
      chk1(analogCtl.sampling, 1'b1);
      n = 0;
      while (analogCtl.sampling === 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      tick(2);
      chk8(8'(wakes - w0), {7'h00, en});
      partner.doze(1'b0);
      rdchk(12'h07c, 8'hc1);
      rdchk(12'h078, 8'hc3);
      wr(12'h030, 8'h40);
   endtask : test_sleep
   task automatic test_abort();
      wr(12'h07c, 8'h01);
      // First pass sleeps on a pending go, second in mid-conversion
      for (int k = 0; k < 2; k++) begin
         xfer(1'b1, 12'h07c, 8'h05);
         tick(3 * k);
         partner.doze(1'b1);
         tick(3);
         chk1(analogCtl.powered, 1'b0);
         chk1(analogCtl.sampling, 1'b0);
         tick(12);
         partner.doze(1'b0);
         rdchk(12'h07c, 8'h01);
         rdchk(12'h030, 8'h00);
      end
   endtask : test_abort
   task automatic test_trigger();
      int c0;
      c0 = clears;
      wr(12'h05c, 8'h0b);
      wr(12'h07c, 8'h01);
      // Acquisition time before the trigger
      tick(4);
      partner.fire();
      tick(2);
      chk8(8'(clears - c0), 8'h01);
      chk1(partner.captureTimer < 16'h0004, 1'b1);
      rdchk(12'h07c, 8'h05);
      waitDone();
      wr(12'h030, 8'h44);
      wr(12'h07c, 8'h00);
      partner.fire();
      tick(2);
      chk8(8'(clears - c0), 8'h02);
      rdchk(12'h07c, 8'h00);
      tick(12);
      rdchk(12'h030, 8'h04);
      wr(12'h030, 8'h04);
      // Other compare modes give no special event
      wr(12'h05c, 8'h0a);
      partner.fire();
      tick(2);
      chk8(8'(clears - c0), 8'h02);
      rdchk(12'h030, 8'h00);
   endtask : test_trigger
   task automatic test_regs();
      wr(12'h014, 8'hff);
      rdchk(12'h014, 8'h3f);
      wr(12'h02c, 8'ha5);
      rdchk(12'h02c, 8'ha5);
      wr(12'h214, 8'h00);
      rdchk(12'h214, 8'h00);
      wr(12'h27c, 8'hff);
      rdchk(12'h27c, 8'h07);
      chk8({5'h00, analogCtl.pinConfig}, 8'h07);
      wr(12'h078, 8'hff);
      rdchk(12'h078, 8'hc3);
   endtask : test_regs
   task automatic test_midreset();
      wr(12'h07c, 8'h01);
      xfer(1'b1, 12'h07c, 8'h05);
      tick(3);
      resetn <= 1'b0;
      tick(2);
      resetn <= 1'b1;
      chk1(analogCtl.sampling, 1'b0);
      chk1(analogCtl.powered, 1'b0);
      chk8({5'h00, analogCtl.pinConfig}, 8'h00);
      rdchk(12'h07c, 8'h00);
      tick(15);
      rdchk(12'h030, 8'h00);
   endtask : test_midreset
   initial begin
      tick(2);
      resetn <= 1'b1;
      test_reset();
      test_soft();
      test_sleep(1'b1);
      test_sleep(1'b0);
      test_abort();
      test_trigger();
      test_regs();
      test_midreset();
      summarize();
   end
   // Whole sequence needs well under a thousand cycles
   initial begin
      tick(5000);
      bad_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      summarize();
   end
endmodule : tb
`default_nettype wire
